//--- src/epsel_params.svh
// Notes on behaviour
// - the selection register answers reads and writes at i/o port address 0x1c00.
// - a changed field reroutes the pins on the very next clock cycle.
// - an address select bit of 1 gives the pin to gpio, 0 keeps address.
// - select bits 5..0 drive address pins 20..15 one to one, reset 0.
// - bits 15, 7 and 6 read zero and ignore writes.
// - parallel mode field sits in bits 14..12, resets to mode 0.
// - mode 001 routes 7 spi, 6 gpio, 4 uart and 4 audio port 2.
// - mode 010 routes 8 gpio signals only.
// - mode 011 routes 4 spi and 4 audio port 3 signals.
// - mode 100 routes 4 audio port 2 and 4 uart signals.
// - mode 101 routes 4 spi and 4 uart signals.
// - mode 110 routes 7 spi, audio ports 2 and 3, 6 gpio.
// - serial port 1 mode in bits 11..10, port 0 in 9..8, reset 00.
// - port 0: 00 card 0, 01 audio 0 plus 2 gpio, 10 six gpio.
// - port 1: 01 audio 1 plus 2 gpio, 10 gpio 11..6, 11 reserved.
`ifndef EPSEL_PARAMS_SVH
`define EPSEL_PARAMS_SVH
`define EPSEL_REG_ADDR 16'h1c00
`define EPSEL_REG_RESET 16'h0000
`define EPSEL_WRITE_MASK 16'h7f3f
`define EPSEL_PP_MSB 14
`define EPSEL_PP_LSB 12
`define EPSEL_SP1_MSB 11
`define EPSEL_SP1_LSB 10
`define EPSEL_SP0_MSB 9
`define EPSEL_SP0_LSB 8
`define EPSEL_ADDR_SEL_MSB 5
`define EPSEL_ADDR_SEL_LSB 0
`define EPSEL_PP_PINS 21
`define EPSEL_SP_PINS 6
`define EPSEL_ADDR_PINS 6
`define EPSEL_SP0_GP_LSB 0
`define EPSEL_SP1_GP_LSB 6
`define EPSEL_ADDR_GP_LSB 21
`endif

//--- src/epsel_pkg.sv
package epsel_pkg;
  typedef enum logic [2:0] {
    EPSEL_PP_MODE0 = 3'b000,
    EPSEL_PP_MODE1 = 3'b001,
    EPSEL_PP_MODE2 = 3'b010,
    EPSEL_PP_MODE3 = 3'b011,
    EPSEL_PP_MODE4 = 3'b100,
    EPSEL_PP_MODE5 = 3'b101,
    EPSEL_PP_MODE6 = 3'b110,
    EPSEL_PP_RSVD = 3'b111
  } epsel_pp_mode_e;
  typedef enum logic [1:0] {
    EPSEL_SP_MODE0 = 2'b00,
    EPSEL_SP_MODE1 = 2'b01,
    EPSEL_SP_MODE2 = 2'b10,
    EPSEL_SP_RSVD = 2'b11
  } epsel_sp_mode_e;
endpackage : epsel_pkg

//--- src/epsel_sync2.sv
`timescale 1ns/1ps
module epsel_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  // first stage feeds only the second one
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end
  assign sync_out = stage2_reg;
endmodule : epsel_sync2

//--- src/epsel_pin_select.sv
`timescale 1ns/1ps
`include "epsel_params.svh"
module epsel_pin_select import epsel_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  input wire logic [6:0] spi_out,
  input wire logic [6:0] spi_oe,
  output logic [6:0] spi_in,
  input wire logic [3:0] uart_out,
  input wire logic [3:0] uart_oe,
  output logic [3:0] uart_in,
  input wire logic [3:0] i2s0_out,
  input wire logic [3:0] i2s0_oe,
  output logic [3:0] i2s0_in,
  input wire logic [3:0] i2s1_out,
  input wire logic [3:0] i2s1_oe,
  output logic [3:0] i2s1_in,
  input wire logic [3:0] i2s2_out,
  input wire logic [3:0] i2s2_oe,
  output logic [3:0] i2s2_in,
  input wire logic [3:0] i2s3_out,
  input wire logic [3:0] i2s3_oe,
  output logic [3:0] i2s3_in,
  input wire logic [5:0] mmc0_out,
  input wire logic [5:0] mmc0_oe,
  output logic [5:0] mmc0_in,
  input wire logic [5:0] mmc1_out,
  input wire logic [5:0] mmc1_oe,
  output logic [5:0] mmc1_in,
  input wire logic [31:0] gpio_out,
  input wire logic [31:0] gpio_oe,
  output logic [31:0] gpio_in,
  input wire logic [5:0] emif_addr_out,
  input wire logic [5:0] emif_addr_oe,
  input wire logic [20:0] pp_pin_in,
  output logic [20:0] pp_pin_out,
  output logic [20:0] pp_pin_oe,
  input wire logic [5:0] sp0_pin_in,
  output logic [5:0] sp0_pin_out,
  output logic [5:0] sp0_pin_oe,
  input wire logic [5:0] sp1_pin_in,
  output logic [5:0] sp1_pin_out,
  output logic [5:0] sp1_pin_oe,
  input wire logic [5:0] addr_pin_in,
  output logic [5:0] addr_pin_out,
  output logic [5:0] addr_pin_oe
);
  // register state
  logic [15:0] sel_reg;
  logic [15:0] sel_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic hit;
  epsel_pp_mode_e pp_mode;
  epsel_sp_mode_e sp0_mode;
  epsel_sp_mode_e sp1_mode;
  logic [5:0] addr_sel;

  assign hit = (io_addr == `EPSEL_REG_ADDR);
  assign pp_mode = epsel_pp_mode_e'(sel_reg[`EPSEL_PP_MSB:`EPSEL_PP_LSB]);
  assign sp1_mode = epsel_sp_mode_e'(sel_reg[`EPSEL_SP1_MSB:`EPSEL_SP1_LSB]);
  assign sp0_mode = epsel_sp_mode_e'(sel_reg[`EPSEL_SP0_MSB:`EPSEL_SP0_LSB]);
  assign addr_sel = sel_reg[`EPSEL_ADDR_SEL_MSB:`EPSEL_ADDR_SEL_LSB];

  always_comb begin
    sel_next = sel_reg;
    rdata_next = rdata_reg;
    if (io_wr && hit) begin
      sel_next = io_wdata & `EPSEL_WRITE_MASK;
    end
    if (io_rd) begin
      if (hit) begin
        rdata_next = sel_reg;
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_reg <= `EPSEL_REG_RESET;
      rdata_reg <= 16'h0000;
    end else begin
      sel_reg <= sel_next;
      rdata_reg <= rdata_next;
    end
  end
  assign io_rdata = rdata_reg;

  // pin inputs come from the package and are synchronised before use
  logic [38:0] pins_async;
  logic [38:0] pins_sync;
  logic [20:0] pp_in_s;
  logic [5:0] sp0_in_s;
  logic [5:0] sp1_in_s;
  logic [5:0] addr_in_s;
  assign pins_async = {addr_pin_in, sp1_pin_in, sp0_pin_in, pp_pin_in};
  epsel_sync2 #(.WIDTH(39)) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );
  assign pp_in_s = pins_sync[20:0];
  assign sp0_in_s = pins_sync[26:21];
  assign sp1_in_s = pins_sync[32:27];
  assign addr_in_s = pins_sync[38:33];

  // parallel port gpio group: gp[20:18] then gp[31:27]
  logic [7:0] ppg_out;
  logic [7:0] ppg_oe;
  assign ppg_out = {gpio_out[31:27], gpio_out[20:18]};
  assign ppg_oe = {gpio_oe[31:27], gpio_oe[20:18]};

  // routing state; registered so every pin follows the field one cycle later
  logic [20:0] pp_out_next;
  logic [20:0] pp_oe_next;
  logic [5:0] sp0_out_next;
  logic [5:0] sp0_oe_next;
  logic [5:0] sp1_out_next;
  logic [5:0] sp1_oe_next;
  logic [5:0] addr_out_next;
  logic [5:0] addr_oe_next;
  logic [6:0] spi_in_next;
  logic [3:0] uart_in_next;
  logic [3:0] i2s0_in_next;
  logic [3:0] i2s1_in_next;
  logic [3:0] i2s2_in_next;
  logic [3:0] i2s3_in_next;
  logic [5:0] mmc0_in_next;
  logic [5:0] mmc1_in_next;
  logic [31:0] gpio_in_next;

  always_comb begin
    logic [7:0] ppg_in;
    ppg_in = 8'h00;
    pp_out_next = 21'h000000;
    pp_oe_next = 21'h000000;
    spi_in_next = 7'h00;
    uart_in_next = 4'h0;
    i2s2_in_next = 4'h0;
    i2s3_in_next = 4'h0;
    // mode 0 and the reserved code leave the parallel pins undriven
    case (pp_mode)
      EPSEL_PP_MODE1: begin
        pp_out_next = {i2s2_out, uart_out, ppg_out[5:0], spi_out};
        pp_oe_next = {i2s2_oe, uart_oe, ppg_oe[5:0], spi_oe};
        spi_in_next = pp_in_s[6:0];
        ppg_in = {2'b00, pp_in_s[12:7]};
        uart_in_next = pp_in_s[16:13];
        i2s2_in_next = pp_in_s[20:17];
      end
      EPSEL_PP_MODE2: begin
        pp_out_next = {13'h0000, ppg_out};
        pp_oe_next = {13'h0000, ppg_oe};
        ppg_in = pp_in_s[7:0];
      end
      EPSEL_PP_MODE3: begin
        pp_out_next = {13'h0000, i2s3_out, spi_out[3:0]};
        pp_oe_next = {13'h0000, i2s3_oe, spi_oe[3:0]};
        spi_in_next = {3'b000, pp_in_s[3:0]};
        i2s3_in_next = pp_in_s[7:4];
      end
      EPSEL_PP_MODE4: begin
        pp_out_next = {13'h0000, uart_out, i2s2_out};
        pp_oe_next = {13'h0000, uart_oe, i2s2_oe};
        i2s2_in_next = pp_in_s[3:0];
        uart_in_next = pp_in_s[7:4];
      end
      EPSEL_PP_MODE5: begin
        pp_out_next = {13'h0000, uart_out, spi_out[3:0]};
        pp_oe_next = {13'h0000, uart_oe, spi_oe[3:0]};
        spi_in_next = {3'b000, pp_in_s[3:0]};
        uart_in_next = pp_in_s[7:4];
      end
      EPSEL_PP_MODE6: begin
        pp_out_next = {ppg_out[5:0], i2s3_out, i2s2_out, spi_out};
        pp_oe_next = {ppg_oe[5:0], i2s3_oe, i2s2_oe, spi_oe};
        spi_in_next = pp_in_s[6:0];
        i2s2_in_next = pp_in_s[10:7];
        i2s3_in_next = pp_in_s[14:11];
        ppg_in = {2'b00, pp_in_s[20:15]};
      end
      default: begin
        pp_out_next = 21'h000000;
        pp_oe_next = 21'h000000;
      end
    endcase

    gpio_in_next = 32'h00000000;
    gpio_in_next[20:18] = ppg_in[2:0];
    gpio_in_next[31:27] = ppg_in[7:3];

    sp0_out_next = 6'h00;
    sp0_oe_next = 6'h00;
    mmc0_in_next = 6'h00;
    i2s0_in_next = 4'h0;
    case (sp0_mode)
      EPSEL_SP_MODE0: begin
        sp0_out_next = mmc0_out;
        sp0_oe_next = mmc0_oe;
        mmc0_in_next = sp0_in_s;
      end
      EPSEL_SP_MODE1: begin
        sp0_out_next = {gpio_out[5:4], i2s0_out};
        sp0_oe_next = {gpio_oe[5:4], i2s0_oe};
        i2s0_in_next = sp0_in_s[3:0];
        gpio_in_next[5:4] = sp0_in_s[5:4];
      end
      EPSEL_SP_MODE2: begin
        sp0_out_next = gpio_out[5:0];
        sp0_oe_next = gpio_oe[5:0];
        gpio_in_next[5:0] = sp0_in_s;
      end
      default: begin
        sp0_oe_next = 6'h00;
      end
    endcase

    sp1_out_next = 6'h00;
    sp1_oe_next = 6'h00;
    mmc1_in_next = 6'h00;
    i2s1_in_next = 4'h0;
    case (sp1_mode)
      EPSEL_SP_MODE0: begin
        sp1_out_next = mmc1_out;
        sp1_oe_next = mmc1_oe;
        mmc1_in_next = sp1_in_s;
      end
      EPSEL_SP_MODE1: begin
        sp1_out_next = {gpio_out[11:10], i2s1_out};
        sp1_oe_next = {gpio_oe[11:10], i2s1_oe};
        i2s1_in_next = sp1_in_s[3:0];
        gpio_in_next[11:10] = sp1_in_s[5:4];
      end
      EPSEL_SP_MODE2: begin
        sp1_out_next = gpio_out[11:6];
        sp1_oe_next = gpio_oe[11:6];
        gpio_in_next[11:6] = sp1_in_s;
      end
      default: begin
        sp1_oe_next = 6'h00;
      end
    endcase

    // each address pin switches on its own select bit
    addr_out_next = (addr_sel & gpio_out[26:21]) | (~addr_sel & emif_addr_out);
    addr_oe_next = (addr_sel & gpio_oe[26:21]) | (~addr_sel & emif_addr_oe);
    gpio_in_next[26:21] = addr_sel & addr_in_s;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pp_pin_out <= 21'h000000;
      pp_pin_oe <= 21'h000000;
      sp0_pin_out <= 6'h00;
      sp0_pin_oe <= 6'h00;
      sp1_pin_out <= 6'h00;
      sp1_pin_oe <= 6'h00;
      addr_pin_out <= 6'h00;
      addr_pin_oe <= 6'h00;
      spi_in <= 7'h00;
      uart_in <= 4'h0;
      i2s0_in <= 4'h0;
      i2s1_in <= 4'h0;
      i2s2_in <= 4'h0;
      i2s3_in <= 4'h0;
      mmc0_in <= 6'h00;
      mmc1_in <= 6'h00;
      gpio_in <= 32'h00000000;
    end else begin
      pp_pin_out <= pp_out_next;
      pp_pin_oe <= pp_oe_next;
      sp0_pin_out <= sp0_out_next;
      sp0_pin_oe <= sp0_oe_next;
      sp1_pin_out <= sp1_out_next;
      sp1_pin_oe <= sp1_oe_next;
      addr_pin_out <= addr_out_next;
      addr_pin_oe <= addr_oe_next;
      spi_in <= spi_in_next;
      uart_in <= uart_in_next;
      i2s0_in <= i2s0_in_next;
      i2s1_in <= i2s1_in_next;
      i2s2_in <= i2s2_in_next;
      i2s3_in <= i2s3_in_next;
      mmc0_in <= mmc0_in_next;
      mmc1_in <= mmc1_in_next;
      gpio_in <= gpio_in_next;
    end
  end

  property p_write_reg;
    @(posedge mclk) disable iff (rst)
      io_wr && io_addr == 16'h1c00 |=> sel_reg == ($past(io_wdata) & 16'h7f3f);
  endproperty
  a_write_reg: assert property (p_write_reg) else $error("register write lost");

  property p_read_reg;
    @(posedge mclk) disable iff (rst)
      io_rd && io_addr == 16'h1c00 && !io_wr |=> io_rdata == $past(sel_reg);
  endproperty
  a_read_reg: assert property (p_read_reg) else $error("read data wrong");

  property p_reserved_zero;
    @(posedge mclk) disable iff (rst)
      io_rd |=> io_rdata[15] == 1'b0 && io_rdata[7:6] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_reset_value;
    @(posedge mclk) rst |=> sel_reg == 16'h0000 && addr_pin_oe == 6'h00;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset value");

  property p_addr_route;
    @(posedge mclk) disable iff (rst)
      io_wr && io_addr == 16'h1c00 ##1 1'b1 |=>
        addr_pin_out == ((sel_reg[5:0] & $past(gpio_out[26:21]))
          | (~sel_reg[5:0] & $past(emif_addr_out)));
  endproperty
  a_addr_route: assert property (p_addr_route) else $error("address pin misrouted");

  property p_addr_gpio;
    @(posedge mclk) disable iff (rst)
      sel_reg[5] |=> addr_pin_oe[5] == $past(gpio_oe[26]);
  endproperty
  a_addr_gpio: assert property (p_addr_gpio) else $error("address pin not gpio");

  property p_mode2_gpio;
    @(posedge mclk) disable iff (rst)
      sel_reg[14:12] == 3'b010 |=> pp_pin_out == {13'h0000, $past(ppg_out)};
  endproperty
  a_mode2_gpio: assert property (p_mode2_gpio) else $error("mode 2 routing wrong");

  property p_mode1_spi;
    @(posedge mclk) disable iff (rst)
      sel_reg[14:12] == 3'b001 |=> pp_pin_oe[6:0] == $past(spi_oe)
        && pp_pin_out[20:17] == $past(i2s2_out);
  endproperty
  a_mode1_spi: assert property (p_mode1_spi) else $error("mode 1 routing wrong");

  property p_rsvd_idle;
    @(posedge mclk) disable iff (rst)
      sel_reg[14:12] == 3'b111 |=> pp_pin_oe == 21'h000000;
  endproperty
  a_rsvd_idle: assert property (p_rsvd_idle) else $error("reserved mode drives");

  property p_sp0_card;
    @(posedge mclk) disable iff (rst)
      sel_reg[9:8] == 2'b00 |=> sp0_pin_out == $past(mmc0_out);
  endproperty
  a_sp0_card: assert property (p_sp0_card) else $error("serial port 0 misrouted");
endmodule : epsel_pin_select

//--- verification/epsel_far_model.sv
`timescale 1ns/1ps
module epsel_far_model (
  input wire logic alt,
  input wire logic [20:0] pp_pin_out,
  input wire logic [20:0] pp_pin_oe,
  input wire logic [5:0] sp0_pin_out,
  input wire logic [5:0] sp0_pin_oe,
  input wire logic [5:0] sp1_pin_out,
  input wire logic [5:0] sp1_pin_oe,
  input wire logic [5:0] addr_pin_out,
  input wire logic [5:0] addr_pin_oe,
  output logic [6:0] spi_out,
  output logic [6:0] spi_oe,
  output logic [3:0] uart_out,
  output logic [3:0] uart_oe,
  output logic [3:0] i2s0_out,
  output logic [3:0] i2s0_oe,
  output logic [3:0] i2s1_out,
  output logic [3:0] i2s1_oe,
  output logic [3:0] i2s2_out,
  output logic [3:0] i2s2_oe,
  output logic [3:0] i2s3_out,
  output logic [3:0] i2s3_oe,
  output logic [5:0] mmc0_out,
  output logic [5:0] mmc0_oe,
  output logic [5:0] mmc1_out,
  output logic [5:0] mmc1_oe,
  output logic [31:0] gpio_out,
  output logic [31:0] gpio_oe,
  output logic [5:0] emif_addr_out,
  output logic [5:0] emif_addr_oe,
  output logic [20:0] pp_pin_in,
  output logic [5:0] sp0_pin_in,
  output logic [5:0] sp1_pin_in,
  output logic [5:0] addr_pin_in
);
  // every source gets its own pattern so a swapped route cannot pass
  assign spi_out = 7'h35 ^ {7{alt}};
  assign spi_oe = 7'h5c ^ {7{alt}};
  assign uart_out = 4'ha ^ {4{alt}};
  assign uart_oe = 4'h6 ^ {4{alt}};
  assign i2s0_out = 4'h3 ^ {4{alt}};
  assign i2s0_oe = 4'h9 ^ {4{alt}};
  assign i2s1_out = 4'hc ^ {4{alt}};
  assign i2s1_oe = 4'h5 ^ {4{alt}};
  assign i2s2_out = 4'h6 ^ {4{alt}};
  assign i2s2_oe = 4'hb ^ {4{alt}};
  assign i2s3_out = 4'h9 ^ {4{alt}};
  assign i2s3_oe = 4'he ^ {4{alt}};
  assign mmc0_out = 6'h2d ^ {6{alt}};
  assign mmc0_oe = 6'h16 ^ {6{alt}};
  assign mmc1_out = 6'h1b ^ {6{alt}};
  assign mmc1_oe = 6'h34 ^ {6{alt}};
  assign gpio_out = 32'h9e3c5a71 ^ {32{alt}};
  assign gpio_oe = 32'h6b1d24e8 ^ {32{alt}};
  assign emif_addr_out = 6'h2a ^ {6{alt}};
  assign emif_addr_oe = 6'h15 ^ {6{alt}};
  // pad level: the device driver wins, otherwise the board pattern shows
  assign pp_pin_in = (pp_pin_oe & pp_pin_out) | (~pp_pin_oe & (21'h0a5c3 ^ {21{alt}}));
  assign sp0_pin_in = (sp0_pin_oe & sp0_pin_out) | (~sp0_pin_oe & 6'h39);
  assign sp1_pin_in = (sp1_pin_oe & sp1_pin_out) | (~sp1_pin_oe & 6'h26);
  assign addr_pin_in = (addr_pin_oe & addr_pin_out) | (~addr_pin_oe & 6'h13);
endmodule : epsel_far_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk, rst, io_wr, io_rd, alt;
  logic [15:0] io_addr, io_wdata, io_rdata, rd_val, prev;
  logic [6:0] spi_out, spi_oe, spi_in;
  logic [3:0] uart_out, uart_oe, uart_in, i2s0_out, i2s0_oe, i2s0_in;
  logic [3:0] i2s1_out, i2s1_oe, i2s1_in, i2s2_out, i2s2_oe, i2s2_in;
  logic [3:0] i2s3_out, i2s3_oe, i2s3_in;
  logic [5:0] mmc0_out, mmc0_oe, mmc0_in, mmc1_out, mmc1_oe, mmc1_in;
  logic [31:0] gpio_out, gpio_oe, gpio_in;
  logic [5:0] emif_addr_out, emif_addr_oe, addr_pin_in, addr_pin_out, addr_pin_oe;
  logic [20:0] pp_pin_in, pp_pin_out, pp_pin_oe;
  logic [5:0] sp0_pin_in, sp0_pin_out, sp0_pin_oe, sp1_pin_in, sp1_pin_out, sp1_pin_oe;
  int errors, n_compared;
  // write data beside the value that should read back
  logic [31:0] rows [8] = '{32'h0000_0000, 32'h1595_1515, 32'haa2a_2a2a, 32'h3f7f_3f3f,
    32'h4001_4001, 32'h5120_5120, 32'h6610_6610, 32'hffff_7f3f};

  epsel_pin_select DUT (.*);
  epsel_far_model far (.*);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    @(negedge mclk);
    rd_val = io_rdata;
  endtask : rd

  function automatic logic [20:0] pp_exp(logic [2:0] m, logic [6:0] s, logic [3:0] u,
      logic [3:0] a2, logic [3:0] a3, logic [7:0] g);
    case (m)
      3'b001: return {a2, u, g[5:0], s};
      3'b010: return {13'h0000, g};
      3'b011: return {13'h0000, a3, s[3:0]};
      3'b100: return {13'h0000, u, a2};
      3'b101: return {13'h0000, u, s[3:0]};
      3'b110: return {g[5:0], a3, a2, s};
      default: return 21'h000000;
    endcase
  endfunction : pp_exp

  function automatic logic [5:0] sp_exp(logic [1:0] m, logic [5:0] c, logic [3:0] a,
      logic [5:0] g);
    case (m)
      2'b00: return c;
      2'b01: return {g[5:4], a};
      2'b10: return g;
      default: return 6'h00;
    endcase
  endfunction : sp_exp

  task automatic check_pins(input logic [15:0] r);
    logic [7:0] go, ge;
    go = {gpio_out[31:27], gpio_out[20:18]};
    ge = {gpio_oe[31:27], gpio_oe[20:18]};
    chk(pp_pin_out, pp_exp(r[14:12], spi_out, uart_out, i2s2_out, i2s3_out, go));
    chk(pp_pin_oe, pp_exp(r[14:12], spi_oe, uart_oe, i2s2_oe, i2s3_oe, ge));
    chk(sp0_pin_out, sp_exp(r[9:8], mmc0_out, i2s0_out, gpio_out[5:0]));
    chk(sp0_pin_oe, sp_exp(r[9:8], mmc0_oe, i2s0_oe, gpio_oe[5:0]));
    chk(sp1_pin_out, sp_exp(r[11:10], mmc1_out, i2s1_out, gpio_out[11:6]));
    chk(sp1_pin_oe, sp_exp(r[11:10], mmc1_oe, i2s1_oe, gpio_oe[11:6]));
    chk(addr_pin_out, (r[5:0] & gpio_out[26:21]) | (~r[5:0] & emif_addr_out));
    chk(addr_pin_oe, (r[5:0] & gpio_oe[26:21]) | (~r[5:0] & emif_addr_oe));
  endtask : check_pins

  task automatic check_ins(input logic [15:0] r);
    logic [6:0] s;
    logic [3:0] u, a2, a3;
    logic [7:0] g;
    logic [31:0] gp;
    s = 7'h00;
    u = 4'h0;
    a2 = 4'h0;
    a3 = 4'h0;
    g = 8'h00;
    case (r[14:12])
      3'b001: begin
        s = pp_pin_in[6:0];
        g = {2'b00, pp_pin_in[12:7]};
        u = pp_pin_in[16:13];
        a2 = pp_pin_in[20:17];
      end
      3'b010: g = pp_pin_in[7:0];
      3'b011: begin
        s = {3'b000, pp_pin_in[3:0]};
        a3 = pp_pin_in[7:4];
      end
      3'b100: begin
        a2 = pp_pin_in[3:0];
        u = pp_pin_in[7:4];
      end
      3'b101: begin
        s = {3'b000, pp_pin_in[3:0]};
        u = pp_pin_in[7:4];
      end
      3'b110: begin
        s = pp_pin_in[6:0];
        a2 = pp_pin_in[10:7];
        a3 = pp_pin_in[14:11];
        g = {2'b00, pp_pin_in[20:15]};
      end
      default: s = 7'h00;
    endcase
    // unrouted gpio inputs read zero
    gp = 32'h00000000;
    gp[20:18] = g[2:0];
    gp[31:27] = g[7:3];
    gp[26:21] = r[5:0] & addr_pin_in;
    if (r[9:8] == 2'b01) gp[5:4] = sp0_pin_in[5:4];
    if (r[9:8] == 2'b10) gp[5:0] = sp0_pin_in;
    if (r[11:10] == 2'b01) gp[11:10] = sp1_pin_in[5:4];
    if (r[11:10] == 2'b10) gp[11:6] = sp1_pin_in;
    chk(spi_in, s);
    chk(uart_in, u);
    chk(i2s2_in, a2);
    chk(i2s3_in, a3);
    chk(mmc0_in, (r[9:8] == 2'b00) ? sp0_pin_in : 6'h00);
    chk(i2s0_in, (r[9:8] == 2'b01) ? sp0_pin_in[3:0] : 4'h0);
    chk(mmc1_in, (r[11:10] == 2'b00) ? sp1_pin_in : 6'h00);
    chk(i2s1_in, (r[11:10] == 2'b01) ? sp1_pin_in[3:0] : 4'h0);
    chk(gpio_in, gp);
  endtask : check_ins

  initial begin
    // a run that hangs must still reach a verdict
    #20000;
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    n_compared = 0;
    {io_wr, io_rd, alt, io_addr, io_wdata} = '0;
    rst = 1'b1;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check_pins(16'h0000);
    rd(16'h1c00);
    chk(rd_val, 16'h0000);
    prev = 16'h0000;
    foreach (rows[i]) begin
      wr(16'h1c00, rows[i][31:16]);
      check_pins(prev);
      @(negedge mclk);
      check_pins(rows[i][15:0]);
      repeat (3) @(negedge mclk);
      check_ins(rows[i][15:0]);
      rd(16'h1c00);
      chk(rd_val, rows[i][15:0]);
      prev = rows[i][15:0];
    end
    // peripheral side change passes through after one edge
    wr(16'h1c00, 16'h1515);
    repeat (2) @(negedge mclk);
    alt = 1'b1;
    @(negedge mclk);
    check_pins(16'h1515);
    // neighbouring addresses must not reach the register
    wr(16'h1c01, 16'h0000);
    rd(16'h1c00);
    chk(rd_val, 16'h1515);
    rd(16'h1c02);
    chk(rd_val, 16'h0000);
    // reset in mid-run returns every field to its default routing
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check_pins(16'h0000);
    rd(16'h1c00);
    chk(rd_val, 16'h0000);
    stop_test();
  end
endmodule : tb
